// [logic/rc_adc_pkg.sv]
// package: constants, register map and types of the rc oscillation converter counters
package rc_adc_pkg;

  // register word offsets (byte addresses on the bus)
  localparam logic [4:0] OFS_TIMER_A_LOW_BYTE   = 5'h00;
  localparam logic [4:0] OFS_TIMER_A_HIGH_BYTE  = 5'h04;
  localparam logic [4:0] OFS_TIMER_B_LOW_BYTE   = 5'h08;
  localparam logic [4:0] OFS_TIMER_B_HIGH_BYTE  = 5'h0C;
  localparam logic [4:0] OFS_TIMER_CONTROL      = 5'h10;
  localparam logic [4:0] OFS_CONVERTER_CONTROL  = 5'h14;
  localparam logic [4:0] OFS_IRQ_STATUS         = 5'h18;
  localparam logic [4:0] OFS_IRQ_MASK           = 5'h1C;

  // field positions
  localparam int RUN_BIT_POS      = 4;
  localparam int TF_BIT_POS       = 4;
  localparam int OVF_SEL_POS      = 0;
  localparam int CONV_EN_POS      = 1;
  localparam int MODE_LSB         = 4;

  // reset values and converter control read mask
  localparam logic [7:0]  TIMER_CONTROL_RST     = 8'h00;
  localparam logic [7:0]  CONVERTER_CONTROL_RST = 8'h00;
  localparam logic [15:0] COUNTER_RST           = 16'h0000;
  localparam logic [7:0]  IRQ_MASK_RST          = 8'h00;
  localparam logic [7:0]  CONV_CTRL_RMASK       = 8'hF3;

  // status bits: 0 overflow a, 1 overflow b, 4 timer flag
  localparam int ST_OVF_A = 0;
  localparam int ST_OVF_B = 1;

  typedef struct packed {
    logic [2:0] tmr_a_sel;
    logic       run;
  } timer_ctrl_s;

  typedef struct packed {
    logic [3:0] mode;
    logic       conv_en;
    logic       ovf_sel;
  } conv_ctrl_s;

  // thirteen switches, bit 0 = first timer a source switch
  typedef logic [12:0] switch_t;

  // timer b switch pattern per mode code 0..7; codes 8..15 = all open
  localparam switch_t SW_MODE_0 = 13'h0800;
  localparam switch_t SW_MODE_1 = 13'h0848;
  localparam switch_t SW_MODE_2 = 13'h0888;
  localparam switch_t SW_MODE_3 = 13'h0828;
  localparam switch_t SW_MODE_4 = 13'h0850;
  localparam switch_t SW_MODE_5 = 13'h1300;
  localparam switch_t SW_MODE_6 = 13'h1500;
  localparam switch_t SW_MODE_7 = 13'h1000;

endpackage

// [logic/up_counter16.sv]
// sixteen bit loadable up counter with low-byte buffers
`timescale 1ns/1ps
module up_counter16
  import rc_adc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        tick,
  input  wire logic        stop,
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic        rd_high,
  input  wire logic [7:0]  wdata,
  // status
  output logic [15:0]      count,
  output logic [7:0]       low_hold,
  output logic             ovf
);

  logic [7:0] low_wbuf;
  wire        wrap = tick & ~stop & (count == 16'hFFFF);

  assign ovf = wrap;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count    <= COUNTER_RST;
      low_wbuf <= 8'h00;
      low_hold <= 8'h00;
    end else begin
      if (wr_low)
        low_wbuf <= wdata;
      if (rd_high)
        low_hold <= count[7:0];
      if (wr_high)
        count <= {wdata, low_wbuf};
      else if (tick && !stop)
        count <= count + 16'h0001;
    end
  end

endmodule

// [logic/rc_adc_counters.sv]
// rc oscillation converter counter pair with wishbone slave and interrupt
`timescale 1ns/1ps
module rc_adc_counters
  import rc_adc_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [4:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic [31:0]      DAT_O,
  output logic             ACK_O,
  // timer a clock sources, already on CLK
  input  wire logic        SYS_CLK_EN,
  input  wire logic        INSTR_CLK_EN,
  input  wire logic        PRESCALER_EN,
  // timer b oscillation networks and external inputs, asynchronous
  input  wire logic        OSC_CH0,
  input  wire logic        OSC_CH1,
  input  wire logic        EXT_CLOCK_IN_CH0,
  input  wire logic        EXT_CLOCK_IN_CH1,
  // switch closures and interrupt
  output logic [12:0]      NETWORK_SWITCHES,
  output logic             TIMER_IRQ_FLAG,
  output logic             IRQ
);

  logic [1:0]  rst_sync;
  wire         rst_n = rst_sync[1];

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  timer_ctrl_s tctl;
  conv_ctrl_s  cctl;
  logic [7:0]  irq_status;
  logic [7:0]  irq_mask;

  // bus decode
  wire        req      = CYC_I & STB_I & ~ACK_O;
  wire        lane0    = SEL_I[0];
  wire        wr       = req & WE_I & lane0;
  wire        rd       = req & ~WE_I;
  wire        hit_al   = ADR_I == OFS_TIMER_A_LOW_BYTE;
  wire        hit_ah   = ADR_I == OFS_TIMER_A_HIGH_BYTE;
  wire        hit_bl   = ADR_I == OFS_TIMER_B_LOW_BYTE;
  wire        hit_bh   = ADR_I == OFS_TIMER_B_HIGH_BYTE;
  wire        hit_tc   = ADR_I == OFS_TIMER_CONTROL;
  wire        hit_cc   = ADR_I == OFS_CONVERTER_CONTROL;
  wire        hit_st   = ADR_I == OFS_IRQ_STATUS;
  wire        hit_mk   = ADR_I == OFS_IRQ_MASK;
  wire [7:0]  wbyte    = DAT_I[7:0];

  // timer b source synchronisers; first stage feeds only the second
  logic [3:0] src_s1;
  logic [3:0] src_s2;
  logic [3:0] src_s3;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      src_s1 <= 4'h0;
      src_s2 <= 4'h0;
      src_s3 <= 4'h0;
    end else begin
      src_s1 <= {EXT_CLOCK_IN_CH1, OSC_CH1, EXT_CLOCK_IN_CH0, OSC_CH0};
      src_s2 <= src_s1;
      src_s3 <= src_s2;
    end
  end

  wire [3:0] src_rise = src_s2 & ~src_s3;

  // switch decode
  wire [2:0] sw_a = (tctl.tmr_a_sel == 3'b000) ? 3'b001 :
                    (tctl.tmr_a_sel == 3'b001) ? 3'b010 :
                    (tctl.tmr_a_sel == 3'b010) ? 3'b100 : 3'b000;

  localparam switch_t SW_B_TAB [0:7] = '{SW_MODE_0, SW_MODE_1, SW_MODE_2, SW_MODE_3,
                                         SW_MODE_4, SW_MODE_5, SW_MODE_6, SW_MODE_7};
  wire switch_t sw_b = cctl.mode[3] ? '0 : SW_B_TAB[cctl.mode[2:0]];

  // timer a tick: system clock, instruction clock or prescaler enable
  wire tick_a = (sw_a[0] & SYS_CLK_EN) | (sw_a[1] & INSTR_CLK_EN) |
                (sw_a[2] & PRESCALER_EN);

  // timer b tick follows the closed network: mode 0 ext ch0, 1..4 osc ch0,
  // 5..6 osc ch1, 7 ext ch1, undefined none
  wire tick_b = cctl.mode[3] ? 1'b0 :
                (cctl.mode[2:0] == 3'd0) ? src_rise[1] :
                (cctl.mode[2:0] == 3'd7) ? src_rise[3] :
                (cctl.mode[2:0] >= 3'd5) ? src_rise[2] : src_rise[0];

  // counters stop while run is low
  wire stop = ~tctl.run;

  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  logic [7:0]  hold_a;
  logic [7:0]  hold_b;
  logic        ovf_a;
  logic        ovf_b;

  up_counter16 u_timer_a (
    .clk      (CLK),
    .rst_n    (rst_n),
    .tick     (tick_a),
    .stop     (stop),
    .wr_low   (wr & hit_al),
    .wr_high  (wr & hit_ah),
    .rd_high  (rd & hit_ah),
    .wdata    (wbyte),
    .count    (cnt_a),
    .low_hold (hold_a),
    .ovf      (ovf_a)
  );

  up_counter16 u_timer_b (
    .clk      (CLK),
    .rst_n    (rst_n),
    .tick     (tick_b & cctl.conv_en),
    .stop     (stop),
    .wr_low   (wr & hit_bl),
    .wr_high  (wr & hit_bh),
    .rd_high  (rd & hit_bh),
    .wdata    (wbyte),
    .count    (cnt_b),
    .low_hold (hold_b),
    .ovf      (ovf_b)
  );

  // in timer mode the select bit is void and timer a overflow is used
  wire sel_ovf  = cctl.conv_en ? (cctl.ovf_sel ? ovf_b : ovf_a) : ovf_a;
  // in converter mode either overflow ends the run
  wire end_run  = cctl.conv_en ? (ovf_a | ovf_b) : ovf_a;

  wire [7:0] ev = {3'b000, sel_ovf, 2'b00, ovf_b, ovf_a};

  // control and status registers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tctl       <= '0;
      cctl       <= '0;
      irq_status <= 8'h00;
      irq_mask   <= IRQ_MASK_RST;
    end else begin
      if (wr && hit_tc)
        tctl <= {wbyte[7:5], wbyte[RUN_BIT_POS]};
      if (end_run)
        tctl.run <= 1'b0;
      if (wr && hit_cc)
        cctl <= {wbyte[7:MODE_LSB], wbyte[CONV_EN_POS], wbyte[OVF_SEL_POS]};
      if (wr && hit_mk)
        irq_mask <= wbyte;
      // new events win over the read clear
      irq_status <= ((rd && hit_st) ? 8'h00 : irq_status) | ev;
    end
  end

  // read mux: low-byte registers return the hold buffers only
  wire [7:0] tc_rd = {tctl.tmr_a_sel, tctl.run, 4'h0};
  wire [7:0] cc_rd = {cctl.mode, 2'b00, cctl.conv_en, cctl.ovf_sel} & CONV_CTRL_RMASK;
  wire [7:0] rmux  = hit_al ? hold_a :
                     hit_ah ? cnt_a[15:8] :
                     hit_bl ? hold_b :
                     hit_bh ? cnt_b[15:8] :
                     hit_tc ? tc_rd :
                     hit_cc ? cc_rd :
                     hit_st ? irq_status :
                     hit_mk ? irq_mask : 8'h00;

  // single wait-free answer: ack one cycle after the request
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ACK_O <= req;
      DAT_O <= rd ? {24'h00_0000, rmux} : 32'h0000_0000;
    end
  end

  assign NETWORK_SWITCHES = {sw_b[12:3], sw_a};
  assign TIMER_IRQ_FLAG   = irq_status[TF_BIT_POS];
  assign IRQ              = |(irq_status & irq_mask);

endmodule

// [sim/rc_adc_counters_checker.sv]
// assertion checker for the rc converter counter pair
`timescale 1ns/1ps
module rc_adc_counters_checker
  import rc_adc_pkg::*;
(
  // bus
  input wire logic        CLK, ARST_N, CYC_I, STB_I, WE_I, ACK_O,
  input wire logic [4:0]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I, DAT_O,
  // switches and interrupt
  input wire logic [12:0] NETWORK_SWITCHES,
  input wire logic        TIMER_IRQ_FLAG, IRQ
);
  logic [7:0] cc, mk, hold;
  logic       hv;
  wire take = CYC_I && STB_I && !ACK_O;
  wire wr   = take && WE_I && SEL_I[0];
  wire rd   = ACK_O && !WE_I;
  wire wack = ACK_O && WE_I && SEL_I[0];
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // shadow copies follow the write edge so they never lag the design
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cc <= 8'h00;
      mk <= 8'h00;
      hold <= 8'h00;
      hv <= 1'h0;
    end else begin
      if (wr && ADR_I == OFS_CONVERTER_CONTROL) cc <= DAT_I[7:0];
      if (wr && ADR_I == OFS_IRQ_MASK) mk <= DAT_I[7:0];
      if (take && ADR_I == OFS_TIMER_A_HIGH_BYTE) hv <= 1'h0;
      if (wr && ADR_I == OFS_TIMER_A_LOW_BYTE) hv <= 1'h0;
      if (rd && ADR_I == OFS_TIMER_A_LOW_BYTE) begin
        hv <= 1'h1;
        hold <= DAT_O[7:0];
      end
    end
  end
  property p_ack; take |=> ACK_O ##1 !ACK_O; endproperty
  a_ack: assert property (p_ack)
    else $error("ack not a single pulse");
  property p_tsel; wack && ADR_I == OFS_TIMER_CONTROL |-> NETWORK_SWITCHES[2:0] ==
    ((DAT_I[7:5] < 3) ? 3'h1 << DAT_I[7:5] : 3'h0); endproperty
  a_tsel: assert property (p_tsel)
    else $error("timer a switch wrong");
  property p_off; wack && ADR_I == OFS_CONVERTER_CONTROL && DAT_I[7]
    |-> NETWORK_SWITCHES[12:3] == 10'h000; endproperty
  a_off: assert property (p_off)
    else $error("switch closed in undefined mode");
  property p_sticky; TIMER_IRQ_FLAG && !(CYC_I && ADR_I == OFS_IRQ_STATUS)
    |=> TIMER_IRQ_FLAG; endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag lost without status read");
  property p_irq; TIMER_IRQ_FLAG && mk[4] |-> ##[0:1] IRQ; endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked flag without irq");
  property p_src; rd && ADR_I == OFS_IRQ_STATUS && DAT_O[4]
    |-> DAT_O[(cc[1] && cc[0]) ? 1 : 0]; endproperty
  a_src: assert property (p_src)
    else $error("flag from wrong overflow");
  property p_ccrd; rd && ADR_I == OFS_CONVERTER_CONTROL
    |-> DAT_O == {24'h00_0000, cc & 8'hF3}; endproperty
  a_ccrd: assert property (p_ccrd)
    else $error("converter control readback wrong");
  property p_hold; rd && ADR_I == OFS_TIMER_A_LOW_BYTE && hv |-> DAT_O[7:0] == hold;
  endproperty
  a_hold: assert property (p_hold)
    else $error("low byte not from holding buffer");
  c_flag: cover property ($rose(TIMER_IRQ_FLAG));
  c_srcb: cover property (rd && ADR_I == OFS_IRQ_STATUS && DAT_O[1]);
  c_off: cover property (wack && ADR_I == OFS_CONVERTER_CONTROL && DAT_I[7]);
endmodule
bind rc_adc_counters rc_adc_counters_checker chk (.CLK, .ARST_N, .CYC_I, .STB_I, .WE_I,
  .ACK_O, .ADR_I, .SEL_I, .DAT_I, .DAT_O, .NETWORK_SWITCHES, .TIMER_IRQ_FLAG, .IRQ);

// [sim/rc_osc_model.sv]
// sensor oscillators and external clocks; quiet and low while not enabled
`timescale 1ns/1ps
module rc_osc_model #(
  parameter realtime HALF = 7.0
) (
  input  wire logic on,
  output logic      osc0, osc1, ext0, ext1
);
  initial {osc0, osc1, ext0, ext1} = 4'h0;
  always #(HALF) osc0 = on & ~osc0;
  always #(HALF * 1.3) osc1 = on & ~osc1;
  always #(HALF * 0.7) ext0 = on & ~ext0;
  always #(HALF * 2.1) ext1 = on & ~ext1;
endmodule

// [sim/test_rc_adc_counters.sv]
// self-checking bench for the rc converter counter pair
`timescale 1ns/1ps
module test_rc_adc_counters
  import rc_adc_pkg::*;
;
  localparam switch_t sw_tab [8] = '{13'h0800, 13'h0848, 13'h0888, 13'h0828,
                                     13'h0850, 13'h1300, 13'h1500, 13'h1000};
  logic        clk = 1'h0, arst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, on = 1'h0;
  logic [2:0]  ce = 3'h0;
  logic [4:0]  adr = 5'h00;
  logic [7:0]  r;
  logic [31:0] dati = 32'h0000_0000;
  wire  logic [31:0] dato;
  wire  logic [12:0] sw;
  wire  logic        ack, flag, irq, o0, o1, e0, e1;
  int bad_count = 0, checks_done = 0, cycles = 0;
  always #2.5 clk = ~clk;
  // slow enough that every source edge survives the two-flop synchroniser
  rc_osc_model #(.HALF(20.0)) osc (.on(on), .osc0(o0), .osc1(o1), .ext0(e0), .ext1(e1));
  rc_adc_counters uut (.CLK(clk), .ARST_N(arst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dati), .DAT_O(dato), .ACK_O(ack),
    .SYS_CLK_EN(ce[0]), .INSTR_CLK_EN(ce[1]), .PRESCALER_EN(ce[2]), .OSC_CH0(o0),
    .OSC_CH1(o1), .EXT_CLOCK_IN_CH0(e0), .EXT_CLOCK_IN_CH1(e1),
    .NETWORK_SWITCHES(sw), .TIMER_IRQ_FLAG(flag), .IRQ(irq));
  task automatic chk(input string nm, input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dati <= {24'h00_0000, v};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 40);
    if (ack !== 1'h1) bad_count++;
    r = dato[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    wb(1'h1, a, v);
  endtask
  task automatic rd(input logic [4:0] a, input string nm, input logic [7:0] e);
    wb(1'h0, a, 8'h00);
    chk(nm, r, e);
  endtask
  // load a counter near its top, start the run, wait for the flag
  task automatic run(input logic [7:0] ctl, m, input logic [4:0] ofs,
                     input logic [7:0] st, tc);
    int n;
    n = 0;
    wr(OFS_IRQ_MASK, m);
    wr(OFS_CONVERTER_CONTROL, ctl);
    wr(ofs, 8'hF0);
    wr(ofs + 5'h04, 8'hFF);
    wr(OFS_TIMER_CONTROL, tc);
    on <= 1'h1;
    while (flag !== 1'h1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("flag", flag, 1);
    on <= 1'h0;
    rd(OFS_TIMER_CONTROL, "control", tc & 8'hE0);
    chk("irq", irq, m[4]);
    rd(ofs + 5'h04, "high", 8'h00);
    wb(1'h0, OFS_IRQ_STATUS, 8'h00);
    chk("status", r & 8'h13, st);
    @(posedge clk);
    chk("irq", irq, 0);
    $display("test run %h done", ctl);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge clk);
    chk("switches", sw, 13'h0801);
    rd(OFS_CONVERTER_CONTROL, "converter", 8'h00);
    rd(5'h03, "unmapped", 8'h00);
    for (int m = 0; m < 16; m++) begin
      wr(OFS_CONVERTER_CONTROL, {m[3:0], 4'h2});
      chk("switches", sw, (m < 8) ? sw_tab[m] | 13'h0001 : 13'h0001);
    end
    for (int s = 0; s < 8; s++) begin
      wr(OFS_TIMER_CONTROL, {s[2:0], 5'h00});
      chk("switches", sw, (s < 3) ? 13'h0001 << s : 13'h0000);
    end
    $display("test switches done");
    ce <= 3'h1;
    wr(OFS_TIMER_A_LOW_BYTE, 8'h34);
    wr(OFS_TIMER_A_HIGH_BYTE, 8'h12);
    wr(OFS_TIMER_A_LOW_BYTE, 8'h56);
    rd(OFS_TIMER_A_HIGH_BYTE, "a high", 8'h12);
    rd(OFS_TIMER_A_LOW_BYTE, "a low", 8'h34);
    $display("test load done");
    run(8'h02, 8'h10, OFS_TIMER_A_LOW_BYTE, 8'h11, 8'h10);
    rd(OFS_TIMER_A_LOW_BYTE, "a low", 8'h00);
    rd(OFS_TIMER_A_LOW_BYTE, "a low", 8'h00);
    run(8'h03, 8'h10, OFS_TIMER_B_LOW_BYTE, 8'h12, 8'h10);
    run(8'h01, 8'h00, OFS_TIMER_A_LOW_BYTE, 8'h11, 8'h10);
    // timer b must have stayed at zero through the timer-mode run
    rd(OFS_TIMER_B_HIGH_BYTE, "b high", 8'h00);
    rd(OFS_TIMER_B_LOW_BYTE, "b low", 8'h00);
    run(8'h13, 8'h10, OFS_TIMER_B_LOW_BYTE, 8'h12, 8'h10);
    run(8'h53, 8'h10, OFS_TIMER_B_LOW_BYTE, 8'h12, 8'h10);
    run(8'h73, 8'h10, OFS_TIMER_B_LOW_BYTE, 8'h12, 8'h10);
    ce <= 3'h2;
    run(8'h02, 8'h10, OFS_TIMER_A_LOW_BYTE, 8'h11, 8'h30);
    ce <= 3'h4;
    run(8'h02, 8'h10, OFS_TIMER_A_LOW_BYTE, 8'h11, 8'h50);
    end_of_test;
  end
endmodule
